// ### logic/pin_mode_pkg.sv
// Constants for the multipurpose pin, mode input and thermal shutdown block.
// Assumes a single 125 MHz clock and asynchronous active-low reset.
package pin_mode_pkg;
   // -----------------------------------------------------------------
   // Clock and timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ           = 125;       // Core clock rate in MHz.
   localparam int MODE_RISE_US      = 40;        // Short rising debounce, us.
   localparam int MODE_RISE_LONG_MS = 10;        // Long rising debounce, ms.
   localparam int MODE_FALL_US      = 70;        // Falling debounce, us.
   localparam int MODE_RISE_CYC     = MODE_RISE_US * CLK_MHZ;
   localparam int MODE_RISE_LONG_CYC = MODE_RISE_LONG_MS * 1000 * CLK_MHZ;
   localparam int MODE_FALL_CYC     = MODE_FALL_US * CLK_MHZ;
   localparam int DB_W              = 21;        // Debounce counter width.

   // -----------------------------------------------------------------
   // Bus address and function codes
   // -----------------------------------------------------------------
   localparam logic [6:0] BUS_ADDR_BASE = 7'h18; // Address base value.
   localparam logic [1:0] CFG_00 = 2'h0;         // Function code 00.
   localparam logic [1:0] CFG_01 = 2'h1;         // Function code 01.
   localparam logic [1:0] CFG_10 = 2'h2;         // Function code 10.
   localparam logic [1:0] CFG_11 = 2'h3;         // Function code 11.
endpackage : pin_mode_pkg

// ### logic/mode_bus_if.sv
// Interface carrying the debounced mode level between internal modules.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface mode_bus_if;
   logic mode_level;     // Debounced mode level, high means pulse-frequency mode when mode_input_select is set.
   modport source (output mode_level);
   modport sink   (input  mode_level);
endinterface : mode_bus_if
`default_nettype wire

// ### logic/mode_debounce.sv
// Debouncer for the shared mode/sync pin with asymmetric edge times.
// Assumes the pin input is already synchronised to clk.
`timescale 1ns/10ps
`default_nettype none
module mode_debounce #(
   parameter int RISE_LONG_CYC = pin_mode_pkg::MODE_RISE_LONG_CYC  // Long rise count.
) (
   input  wire logic       clk,        // Core clock.
   input  wire logic       rstn,       // Async reset, active low.
   input  wire logic       pin_sync,   // Synchronised pin level.
   input  wire logic       long_db,    // Long rising debounce option.
   mode_bus_if.source      mode_out    // Debounced level out.
);
   logic            level_q, level_d;  // Accepted level.
   logic [pin_mode_pkg::DB_W-1:0] cnt_q, cnt_d; // Stable time counter.
   logic [pin_mode_pkg::DB_W-1:0] target;       // Count needed for this edge.

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   // RULE16 edge dependent debounce.
   always_comb begin
      if (!level_q) begin
         target = long_db ? RISE_LONG_CYC[pin_mode_pkg::DB_W-1:0]
                          : pin_mode_pkg::MODE_RISE_CYC[pin_mode_pkg::DB_W-1:0];
      end else begin
         target = pin_mode_pkg::MODE_FALL_CYC[pin_mode_pkg::DB_W-1:0];
      end
      level_d = level_q;
      cnt_d   = '0;
      // A glitch back to the accepted level restarts the timer.
      if (pin_sync != level_q) begin
         if (cnt_q + 1'b1 >= target) begin
            level_d = pin_sync;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         level_q <= 1'b0;
         cnt_q   <= '0;
      end else begin
         level_q <= level_d;
         cnt_q   <= cnt_d;
      end
   end

   assign mode_out.mode_level = level_q;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_fall_needs_time;
      @(posedge clk) disable iff (!rstn)
         $fell(level_q) |-> $past(cnt_q) == pin_mode_pkg::MODE_FALL_CYC - 1;
   endproperty
   a_fall_needs_time: assert property (p_fall_needs_time) // RULE16
      else $error("Mode level fell before the falling debounce time.");

   property p_rise_needs_time;
      @(posedge clk) disable iff (!rstn)
         $rose(level_q) |-> $past(cnt_q) == (($past(long_db) ? RISE_LONG_CYC
                            : pin_mode_pkg::MODE_RISE_CYC) - 1);
   endproperty
   a_rise_needs_time: assert property (p_rise_needs_time) // RULE16
      else $error("Mode level rose before the rising debounce time.");

   property p_cover_rise;
      @(posedge clk) disable iff (!rstn) $rose(level_q);
   endproperty
   c_cover_rise: cover property (p_cover_rise);
endmodule : mode_debounce
`default_nettype wire

// ### logic/pin_function_mode_select.sv
// Top of the multipurpose pin, regulation mode and thermal shutdown block.
// Assumes configuration bits are static after power-up and pins are asynchronous.
//
// What this block does
// RULE1: Mode pin used only when select bit set.
// RULE2: Mode low commands continuous PWM switching.
// RULE3: Mode high commands PFM and low-quiescent shutdown.
// RULE4: Power-good outputs track own converter in PFM.
// RULE5: Low-quiescent enable forced on non-safety variants.
// RULE6: Host bus supports up to 3.4 MHz.
// RULE7: Device is bus target only.
// RULE8: Bus address is 0x18 plus select value.
// RULE9: Overtemperature trip enters thermal shutdown.
// RULE10: Shutdown sets flag held until power-up.
// RULE11: Shutdown disables converters, drives outputs low immediately.
// RULE12: Each pin's function from its own field.
// RULE13: Pin 1 decode: hi-Z, output, monitor, reserved.
// RULE14: Pin 2 decode: output, fault, sync, monitor.
// RULE15: Pin 3 decode: output, fault, monitor, monitor.
// RULE16: Mode debounce 40us/10ms rising, 70us falling.
// RULE17: Reserved pin 1 code holds hi-Z, ignores input.
`timescale 1ns/10ps
`default_nettype none
module pin_function_mode_select #(
   parameter int RISE_LONG_CYC = pin_mode_pkg::MODE_RISE_LONG_CYC  // Long rise count.
) (
   input  wire logic       clk,               // Core clock, 125 MHz.
   input  wire logic       rstn,              // Async reset, active low.
   input  wire logic       mode_input_select, // Shared pin acts as mode input.
   input  wire logic       mode_long_debounce_option, // Long rising debounce.
   input  wire logic       safety_variant,    // High on safety variants.
   input  wire logic       low_quiescent_enable, // Programmed low-power option.
   input  wire logic [1:0] pin1_function_select, // Pin 1 function field.
   input  wire logic [1:0] pin2_function_select, // Pin 2 function field.
   input  wire logic [1:0] pin3_function_select, // Pin 3 function field.
   input  wire logic [2:0] bus_addr_select,   // Programmed address low bits.
   input  wire logic       mode_sync_shared_pin, // Shared pin level.
   input  wire logic       overtemp_trip,     // Sensor says die above trip.
   input  wire logic       conv1_en_req,      // Converter 1 enable request.
   input  wire logic       conv2_en_req,      // Converter 2 enable request.
   input  wire logic       conv1_in_reg,      // Converter 1 in regulation.
   input  wire logic       conv2_in_reg,      // Converter 2 in regulation.
   input  wire logic [2:0] general_output_val, // Requested general output levels.
   input  wire logic       sync_clock,        // Switching sync from oscillator.
   input  wire logic [2:0] pin_in,            // Multipurpose pin input levels.
   output logic [2:0]      pin_out,           // Multipurpose pin drive level.
   output logic [2:0]      pin_oe_n,          // Pin drive enable, low drives.
   output logic            buck_converter_1_en, // Converter 1 enable.
   output logic            buck_converter_2_en, // Converter 2 enable.
   output logic            pfm_mode,          // High selects PFM for both.
   output logic            low_q_shutdown,    // Switch off internal circuits.
   output logic            low_q_mode_eff,    // Effective low-quiescent option.
   output logic            power_good_out_1,  // Converter 1 good.
   output logic            power_good_out_2,  // Converter 2 good.
   output logic [6:0]      bus_target_addr,   // Seven-bit target address.
   output logic            overtemp_latched_flag, // Sticky thermal flag.
   output logic            error_monitor_in_1, // Routed monitor input 1.
   output logic            error_monitor_in_2, // Routed monitor input 2.
   output logic            fault_collector_in_1, // Routed fault input 1.
   output logic            fault_collector_in_2, // Routed fault input 2.
   output logic            voltage_monitor_in_3, // Routed monitor input 3.
   output logic            voltage_monitor_in_4  // Routed monitor input 4.
);
   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   logic [5:0] sync1_q, sync2_q;      // Two-stage sync for async inputs.
   logic [5:0] async_in;              // Raw asynchronous inputs.
   assign async_in = {overtemp_trip, mode_sync_shared_pin, pin_in, sync_clock};

   // Only the second stage is read by logic below.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end

   logic       ot_s, mode_s, sync_s;  // Synchronised single inputs.
   logic [2:0] pin_s;                 // Synchronised pin inputs.
   assign {ot_s, mode_s, pin_s, sync_s} = sync2_q;

   // -----------------------------------------------------------------
   // Mode debounce
   // -----------------------------------------------------------------
   mode_bus_if mode_bus ();
   mode_debounce #(.RISE_LONG_CYC(RISE_LONG_CYC)) u_db (
      .clk      (clk),
      .rstn     (rstn),
      .pin_sync (mode_s),
      .long_db  (mode_long_debounce_option),
      .mode_out (mode_bus.source)
   );

   // -----------------------------------------------------------------
   // Thermal shutdown latch
   // -----------------------------------------------------------------
   logic ot_q, ot_d;  // Sticky; only power-up reset clears it.

   // RULE9 trip enters shutdown.
   always_comb begin
      ot_d = ot_q | ot_s;
   end

   // RULE10 flag held until reset.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ot_q <= 1'b0;
      end else begin
         ot_q <= ot_d;
      end
   end

   // -----------------------------------------------------------------
   // Output decode
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] out;
      logic [2:0] oe_n;
      logic       en1, en2, pfm, lqs, lqm, pg1, pg2;
      logic [6:0] addr;
      logic [5:0] mon;  // em1, em2, fc1, fc2, vm3, vm4.
   } out_type;
   out_type o_q, o_d;
   logic    mode_hi;  // Effective mode level.
   logic    shut;     // Shutdown takes effect the same cycle as the trip.

   always_comb begin
      shut = ot_q | ot_s;
      // RULE1 honour pin only if selected.
      mode_hi = mode_input_select & mode_bus.mode_level;
      o_d = '0;
      o_d.oe_n = 3'h7;
      // RULE11 converters off at once.
      o_d.en1 = conv1_en_req & ~shut;
      o_d.en2 = conv2_en_req & ~shut;
      // RULE2 low is PWM; RULE3 high is PFM.
      o_d.pfm = mode_hi;
      o_d.lqs = mode_hi;
      // RULE5 forced on for non-safety parts.
      o_d.lqm = safety_variant ? low_quiescent_enable : 1'b1;
      // RULE4 each good tracks its own converter.
      o_d.pg1 = conv1_in_reg;
      o_d.pg2 = conv2_in_reg;
      // RULE8 base plus select.
      // RULE6 RULE7 target address only; the host clocks every transfer.
      o_d.addr = pin_mode_pkg::BUS_ADDR_BASE | {4'h0, bus_addr_select};
      // RULE12 fields decoded independently; RULE13 pin 1.
      unique case (pin1_function_select)
         pin_mode_pkg::CFG_00: ;
         pin_mode_pkg::CFG_01: begin
            o_d.out[0] = general_output_val[0];
            o_d.oe_n[0] = 1'b0;
         end
         pin_mode_pkg::CFG_10: o_d.mon[5] = pin_s[0];
         // RULE17 reserved stays hi-Z, input ignored.
         pin_mode_pkg::CFG_11: ;
      endcase
      // RULE14 pin 2.
      unique case (pin2_function_select)
         pin_mode_pkg::CFG_00: begin
            o_d.out[1] = general_output_val[1];
            o_d.oe_n[1] = 1'b0;
         end
         pin_mode_pkg::CFG_01: o_d.mon[3] = pin_s[1];
         pin_mode_pkg::CFG_10: begin
            o_d.out[1] = sync_s;
            o_d.oe_n[1] = 1'b0;
         end
         pin_mode_pkg::CFG_11: o_d.mon[1] = pin_s[1];
      endcase
      // RULE15 pin 3.
      unique case (pin3_function_select)
         pin_mode_pkg::CFG_00: begin
            o_d.out[2] = general_output_val[2];
            o_d.oe_n[2] = 1'b0;
         end
         pin_mode_pkg::CFG_01: o_d.mon[2] = pin_s[2];
         pin_mode_pkg::CFG_10: o_d.mon[4] = pin_s[2];
         pin_mode_pkg::CFG_11: o_d.mon[0] = pin_s[2];
      endcase
      // RULE11 driven outputs forced low.
      if (shut) begin
         o_d.out = 3'h0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         o_q <= '{out: 3'h0, oe_n: 3'h7, addr: 7'h00, mon: 6'h00, default: 1'b0};
      end else begin
         o_q <= o_d;
      end
   end

   assign pin_out               = o_q.out;
   assign pin_oe_n              = o_q.oe_n;
   assign buck_converter_1_en   = o_q.en1;
   assign buck_converter_2_en   = o_q.en2;
   assign pfm_mode              = o_q.pfm;
   assign low_q_shutdown        = o_q.lqs;
   assign low_q_mode_eff        = o_q.lqm;
   assign power_good_out_1      = o_q.pg1;
   assign power_good_out_2      = o_q.pg2;
   assign bus_target_addr       = o_q.addr;
   assign overtemp_latched_flag = ot_q;
   assign {error_monitor_in_1, error_monitor_in_2, fault_collector_in_1,
           fault_collector_in_2, voltage_monitor_in_3, voltage_monitor_in_4} = o_q.mon;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_flag_sticky;
      @(posedge clk) disable iff (!rstn) ot_q |=> ot_q [*8];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) // RULE10
      else $error("Overtemperature flag dropped.");

   property p_shut_off;
      @(posedge clk) disable iff (!rstn)
         ot_q |-> !buck_converter_1_en && !buck_converter_2_en && pin_out == 3'h0;
   endproperty
   a_shut_off: assert property (p_shut_off) // RULE11
      else $error("Output active during thermal shutdown.");

   property p_trip_sets;
      @(posedge clk) disable iff (!rstn) $rose(ot_s) |=> ot_q;
   endproperty
   a_trip_sets: assert property (p_trip_sets) // RULE9
      else $error("Trip did not set shutdown.");

   property p_mode_ignored;
      @(posedge clk) disable iff (!rstn) !$past(mode_input_select) |-> !pfm_mode;
   endproperty
   a_mode_ignored: assert property (p_mode_ignored) // RULE1
      else $error("PFM without mode select.");

   // The edge that releases reset still loads reset values, so the checks below that
   // compare against last cycle's inputs only start once reset was high a cycle ago.
   property p_pfm_follows;
      @(posedge clk) disable iff (!rstn)
         $past(rstn) |-> pfm_mode == ($past(mode_input_select) & $past(mode_bus.mode_level))
         && low_q_shutdown == pfm_mode;
   endproperty
   a_pfm_follows: assert property (p_pfm_follows) // RULE3
      else $error("Mode output not following mode level.");

   property p_addr;
      @(posedge clk) disable iff (!rstn)
         $past(rstn) |-> bus_target_addr == 7'h18 + {4'h0, $past(bus_addr_select)};
   endproperty
   a_addr: assert property (p_addr) // RULE8
      else $error("Bus address wrong.");

   property p_pg;
      @(posedge clk) disable iff (!rstn)
         $past(rstn) |-> power_good_out_1 == $past(conv1_in_reg)
            && power_good_out_2 == $past(conv2_in_reg);
   endproperty
   a_pg: assert property (p_pg) // RULE4
      else $error("Power-good not tracking converter.");

   property p_lq;
      @(posedge clk) disable iff (!rstn)
         $past(rstn) && !$past(safety_variant) |-> low_q_mode_eff;
   endproperty
   a_lq: assert property (p_lq) // RULE5
      else $error("Low-quiescent not forced on.");

   property p_pin1_res;
      @(posedge clk) disable iff (!rstn)
         $past(rstn) && $past(pin1_function_select) == 2'h3
            |-> pin_oe_n[0] && !error_monitor_in_1;
   endproperty
   a_pin1_res: assert property (p_pin1_res) // RULE17
      else $error("Reserved pin 1 code not idle.");

   property p_pin2_sync;
      @(posedge clk) disable iff (!rstn)
         $past(rstn) && $past(pin2_function_select) == 2'h2 |-> !pin_oe_n[1];
   endproperty
   a_pin2_sync: assert property (p_pin2_sync) // RULE14
      else $error("Pin 2 sync output not driven.");

   property p_cov_shut;
      @(posedge clk) disable iff (!rstn) $rose(ot_q);
   endproperty
   c_cov_shut: cover property (p_cov_shut);

   property p_cov_pfm;
      @(posedge clk) disable iff (!rstn) $rose(pfm_mode);
   endproperty
   c_cov_pfm: cover property (p_cov_pfm);
endmodule : pin_function_mode_select
`default_nettype wire

// ### bench/ext_pin_model.sv
// Model of the board around the three multipurpose pins.
// Assumes each pin has a pull-up and may be driven from outside when the block lets go.
`timescale 1ns/10ps
`default_nettype none
module ext_pin_model (
   input  wire logic [2:0] pin_out,  // Block drive level.
   input  wire logic [2:0] pin_oe_n, // Block drive enable, low drives.
   input  wire logic [2:0] ext_en,   // Outside driver present.
   input  wire logic [2:0] ext_val,  // Outside driver level.
   output logic      [2:0] pin_in    // Resolved wire level.
);
   // ------------------------------------------------------------
   // Wire resolution
   // ------------------------------------------------------------
   // The block wins while it drives; otherwise the outside driver or the pull-up.
   // A released pin must not echo the last driven value, so the outside driver or else the pull-up decides.
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (pin_oe_n[i] == 1'b0) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else begin
            pin_in[i] = 1'b1;
         end
      end
   end
endmodule : ext_pin_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the pin function, mode and thermal block.
// Assumes the long rising debounce is shortened to 50 cycles for simulation.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int LONG_CYC = 50; // Shortened long rising debounce.
   logic       clk = 1'b0;       // Core clock.
   logic       rstn = 1'b0;      // Reset, active low.
   logic       msel = 1'b0, mlong = 1'b0, safety = 1'b0, lqe = 1'b0, mpin = 1'b0;
   logic       ot = 1'b0, en1 = 1'b0, en2 = 1'b0, rg1 = 1'b0, rg2 = 1'b0, syn = 1'b0;
   logic [1:0] c1 = 2'h0, c2 = 2'h0, c3 = 2'h0; // Pin function fields.
   logic [2:0] asel = 3'h0, gov = 3'h0, xen = 3'h0, xval = 3'h0; // Address, outputs, far side.
   logic [2:0] pin_in, pin_out, pin_oe_n; // Pin wires.
   logic       b1, b2, pfm, lqs, lqeff, pg1, pg2, flag, em1, em2, fc1, fc2, vm3, vm4;
   logic [6:0] addr;             // Target address.
   int         n_mismatch = 0;   // Mismatch count.
   int         comparisons = 0;  // Comparison count.
   int         cycles = 0;       // Cycles since start.
   // ------------------------------------------------------------
   // Clock, design and far side
   // ------------------------------------------------------------
   initial begin
      forever #4 clk = ~clk;
   end
   pin_function_mode_select #(.RISE_LONG_CYC(LONG_CYC)) dut (
      .clk(clk), .rstn(rstn), .mode_input_select(msel), .mode_long_debounce_option(mlong),
      .safety_variant(safety), .low_quiescent_enable(lqe), .pin1_function_select(c1),
      .pin2_function_select(c2), .pin3_function_select(c3), .bus_addr_select(asel),
      .mode_sync_shared_pin(mpin), .overtemp_trip(ot), .conv1_en_req(en1),
      .conv2_en_req(en2), .conv1_in_reg(rg1), .conv2_in_reg(rg2),
      .general_output_val(gov), .sync_clock(syn), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .buck_converter_1_en(b1), .buck_converter_2_en(b2),
      .pfm_mode(pfm), .low_q_shutdown(lqs), .low_q_mode_eff(lqeff),
      .power_good_out_1(pg1), .power_good_out_2(pg2), .bus_target_addr(addr),
      .overtemp_latched_flag(flag), .error_monitor_in_1(em1), .error_monitor_in_2(em2),
      .fault_collector_in_1(fc1), .fault_collector_in_2(fc2),
      .voltage_monitor_in_3(vm3), .voltage_monitor_in_4(vm4));
   ext_pin_model far_side (
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(xen), .ext_val(xval), .pin_in(pin_in));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Waits whole cycles and samples just after the edge so outputs have settled.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // Sets all three fields at once so a field leaking into a neighbour pin shows up.
   task automatic pins_case(input logic [1:0] a, b, c, input logic [2:0] g, x);
      logic [2:0] oe, dv;
      logic [5:0] mon;
      @(posedge clk);
      c1 <= a; c2 <= b; c3 <= c; gov <= g; xval <= x; xen <= 3'h7; syn <= ~g[1];
      step(6);
      oe = {c != 2'h0, !(b == 2'h0 || b == 2'h2), a != 2'h1};
      dv = {g[2], (b == 2'h2) ? ~g[1] : g[1], g[0]};
      mon = {a == 2'h2 && x[0], c == 2'h2 && x[2], b == 2'h1 && x[1],
             c == 2'h1 && x[2], b == 2'h3 && x[1], c == 2'h3 && x[2]};
      chk({5'h00, pin_oe_n}, {5'h00, oe}, "pin drive enables");
      chk({5'h00, pin_out | oe}, {5'h00, dv | oe}, "pin drive levels");
      chk({2'h0, em1, em2, fc1, fc2, vm3, vm4}, {2'h0, mon}, "routed inputs");
   endtask : pins_case
   // Ends the run in one place with the verdict.
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   // A hang shows up as running past a ceiling well above the planned length.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 45000) begin
         n_mismatch++;
         $display("unexpected at %0t: run did not finish", $time);
         tally_and_finish();
      end
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      step(4);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         asel <= i[2:0];
         step(3);
         chk({1'b0, addr}, 8'h18 + i[7:0], "bus address");
      end
      $display("address test done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {safety, lqe} <= i[1:0];
         step(3);
         chk({7'h00, lqeff}, {7'h00, !i[1] | i[0]}, "low-quiescent option");
      end
      $display("low-quiescent test done");
      for (int i = 0; i < 4; i++) begin
         pins_case(i[1:0], i[1:0], i[1:0], 3'h6, 3'h5);
         pins_case(i[1:0], i[1:0] + 2'h1, i[1:0] + 2'h2, 3'h1, 3'h2);
      end
      $display("pin decode test done");
      // mode pin ignored when not selected
      @(posedge clk);
      mpin <= 1'b1;
      step(5200);
      chk({7'h00, pfm}, 8'h00, "mode ignored");
      @(posedge clk);
      mpin <= 1'b0;
      msel <= 1'b1;
      step(8800);
      @(posedge clk);
      mpin <= 1'b1;
      step(4900);
      chk({7'h00, pfm}, 8'h00, "rise too early");
      step(200);
      chk({6'h00, pfm, lqs}, 8'h03, "pulse-frequency mode");
      @(posedge clk);
      rg1 <= 1'b1;
      step(3);
      chk({6'h00, pg1, pg2}, 8'h02, "power good 1 in pfm");
      @(posedge clk);
      rg1 <= 1'b0;
      rg2 <= 1'b1;
      step(3);
      chk({6'h00, pg1, pg2}, 8'h01, "power good 2 in pfm");
      @(posedge clk);
      mpin <= 1'b0;
      step(8700);
      chk({7'h00, pfm}, 8'h01, "fall too early");
      step(100);
      chk({6'h00, pfm, lqs}, 8'h00, "continuous switching");
      @(posedge clk);
      mlong <= 1'b1;
      mpin <= 1'b1;
      step(LONG_CYC - 10);
      chk({7'h00, pfm}, 8'h00, "long rise too early");
      step(20);
      chk({7'h00, pfm}, 8'h01, "long rise");
      $display("mode test done");
      pins_case(2'h1, 2'h0, 2'h0, 3'h7, 3'h7);
      @(posedge clk);
      en1 <= 1'b1;
      en2 <= 1'b1;
      step(3);
      chk({5'h00, flag, b1, b2}, 8'h03, "converters on");
      @(posedge clk);
      ot <= 1'b1;
      step(4);
      @(posedge clk);
      ot <= 1'b0;
      step(5);
      chk({5'h00, flag, b1, b2}, 8'h04, "shutdown");
      chk({5'h00, pin_out}, 8'h00, "outputs low");
      step(100);
      chk({7'h00, flag}, 8'h01, "flag held");
      @(posedge clk);
      rstn <= 1'b0;
      step(16);
      @(posedge clk);
      rstn <= 1'b1;
      step(4);
      chk({7'h00, flag}, 8'h00, "flag cleared by power-up");
      $display("thermal test done");
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
